//--- src/rx_sar_regs_pkg.sv
package rx_sar_regs_pkg;
    // register byte addresses on the microprocessor port
    localparam logic [11:0] TX_CELL_MONITOR_ADDR = 12'h310;
    localparam logic [11:0] RX_CONTROL_ADDR = 12'h400;
    localparam logic [11:0] RX_OVERFLOW_STATUS_ADDR = 12'h402;
    localparam logic [11:0] RX_OVERFLOW_IRQ_ENABLE_ADDR = 12'h404;
    localparam logic [11:0] PCM_SILENCE_PATTERN_ADDR = 12'h410;
    localparam logic [11:0] HDLC_CRC_START_VALUE_ADDR = 12'h428;
    localparam logic [11:0] HDLC_CRC_FINAL_MASK_ADDR = 12'h42a;
    localparam logic [11:0] RX_CELL_FIFO_PLACEMENT_ADDR = 12'h430;
    localparam logic [11:0] RX_CELL_FIFO_READ_PTR_ADDR = 12'h432;
    localparam logic [11:0] RX_CELL_FIFO_WRITE_PTR_ADDR = 12'h434;
    // field positions
    localparam int TX_CELL_SLOT_FREE_BIT = 0;
    localparam int HDLC_TYPE_BIT = 0;
    localparam int PACKAGING_BIT = 1;
    localparam int NIBBLE_BIT = 2;
    localparam int HOST_PKT_OVF_BIT = 0;
    localparam int RX_CELL_OVF_BIT = 1;
    localparam int EVENT_OVF_BIT = 2;
    localparam int FIFO_BASE_LSB = 0;
    localparam int FIFO_SIZE_LSB = 9;
    localparam int FIFO_BASE_ADDR_LSB = 12;
    // values after reset
    localparam logic [15:0] PCM_SILENCE_RESET = 16'h00ff;
    localparam logic [15:0] CRC_START_RESET = 16'hffff;
    localparam logic [15:0] CRC_MASK_RESET = 16'hf0b8;
    // fifo geometry: size code 0 is 4 KB, each code doubles it
    localparam logic [2:0] FIFO_SIZE_CODE_MAX = 3'h5;
    localparam int CELL_SLOT_LOG2 = 6;
    localparam int TX_FIFO_DEPTH_DEFAULT = 4;
endpackage

//--- src/overflow_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
module overflow_flag_bank
    import rx_sar_regs_pkg::*;
#(
    parameter int FLAGS = 3
) (
    input wire logic ref_clk, // core clock
    input wire logic reset, // async, active high
    input wire logic [FLAGS-1:0] setPulse, // overflow events
    input wire logic [FLAGS-1:0] clearMask, // clear on status read
    output logic [FLAGS-1:0] flags // latched flags
);
    typedef struct packed {
        logic [FLAGS-1:0] flags;
    } bank_t;
    bank_t state;
    bank_t next_state;
    logic [FLAGS-1:0] nextBit;

    ////////////////////////////////////////////////////////////////////
    // per flag: a set in the clearing cycle survives
    genvar i;
    for (i = 0; i < FLAGS; i++) begin : g_flag
        assign nextBit[i] = setPulse[i] | (state.flags[i] & ~clearMask[i]);
    end

    always_comb begin
        next_state = state;
        next_state.flags = nextBit;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flags = state.flags;
endmodule
`default_nettype wire

//--- src/rx_cell_fifo_ptr.sv
`timescale 1ns/1ps
`default_nettype none
module rx_cell_fifo_ptr
    import rx_sar_regs_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire logic reset, // async, active high
    input wire logic [2:0] sizeCode, // fifo size code
    input wire logic [8:0] base, // address bits 20:12
    input wire logic [11:0] rdPtr, // host read pointer
    input wire logic storeReq, // a cell arrives
    output logic storeAccept, // cell stored this cycle
    output logic overflowPulse, // cell dropped, fifo full
    output logic fifoFull, // full level
    output logic fifoEmpty, // empty level
    output logic [11:0] wrPtr, // hardware write pointer
    output logic [20:0] storeAddr // byte address of write slot
);
    typedef struct packed {
        logic [11:0] wrPtr;
    } ptr_t;
    ptr_t state;
    ptr_t next_state;
    logic [3:0] idxBits;
    logic [11:0] wrapOnly;
    logic [11:0] ptrMask;
    logic [11:0] diff;

    ////////////////////////////////////////////////////////////////////
    // reserved size codes behave as the largest size
    always_comb begin
        idxBits = (sizeCode > FIFO_SIZE_CODE_MAX) ? 4'(FIFO_SIZE_CODE_MAX) : 4'(sizeCode);
        idxBits = idxBits + 4'(CELL_SLOT_LOG2);
        wrapOnly = 12'h001 << idxBits;
        ptrMask = (wrapOnly << 1) - 12'h001;
        diff = (wrPtr ^ rdPtr) & ptrMask;
    end

    // equal is empty, wrap bit only is full
    assign fifoEmpty = (diff == 12'h000);
    assign fifoFull = (diff == wrapOnly);
    assign storeAccept = storeReq & ~fifoFull;
    assign overflowPulse = storeReq & fifoFull;

    always_comb begin
        next_state = state;
        if (storeAccept) begin
            next_state.wrPtr = (state.wrPtr + 12'h001) & ptrMask;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign wrPtr = state.wrPtr;
    // base sits at bits 20:12, slot index above the cell offset
    assign storeAddr = 21'({base, 12'h000}) + 21'({wrPtr & (wrapOnly - 12'h001), 6'h00});
endmodule
`default_nettype wire

//--- src/rx_sar_control_status_regs.sv
// How it works
// - monitor bit 0 reads 1 while the transmit cell fifo has room.
// - control bit 0 picks bit-wide (0) or byte-wide (1) HDLC framing.
// - control bit 1 picks bare payload (0) or raw CPS packet (1).
// - control bit 2 picks high (0) or low (1) ADPCM nibble.
// - status bit 0 latches host packet buffer overflow.
// - status bit 1 latches receive cell fifo overflow.
// - status bit 2 latches event buffer overflow.
// - interrupt when any status flag and its matching enable are both set.
// - silence pattern, reset 00ff, feeds the write-back path.
// - CRC start value register, reset ffff, seeds the HDLC CRC.
// - CRC end mask register, reset f0b8, used by the HDLC check.
// - fifo base field supplies byte address bits 20:12.
// - size code 0..5 selects 4 to 128 KB; others reserved.
// - hardware advances a read-only 12-bit write pointer with wrap bit.
`timescale 1ns/1ps
`default_nettype none
module rx_sar_control_status_regs
    import rx_sar_regs_pkg::*;
#(
    parameter int TX_FIFO_DEPTH = TX_FIFO_DEPTH_DEFAULT
) (
    input wire logic ref_clk, // core clock, 100 MHz
    input wire logic reset, // async, active high
    input wire logic [11:0] cpuAddr, // register byte address
    input wire logic cpuWr, // write strobe, one cycle
    input wire logic cpuRd, // read strobe, one cycle
    input wire logic [15:0] cpuWrData, // write data
    output logic [15:0] cpuRdData, // read data, registered
    output logic cpuRdValid, // read data valid pulse
    input wire logic [2:0] txFifoLevel, // cells held in tx fifo
    input wire logic hostPktBufOvf, // host packet buffer overflow pulse
    input wire logic eventBufOvf, // event buffer overflow pulse
    input wire logic rxCellReq, // receive cell to store, pulse
    output logic rxCellAccept, // cell taken this cycle
    output logic [20:0] rxCellAddr, // byte address for the cell
    output logic rxCellFifoFull, // fifo full level
    output logic rxCellFifoEmpty, // fifo empty level
    output logic hdlcByteMode, // byte-wide HDLC framing
    output logic rawCpsPacking, // raw CPS packet in HDLC data
    output logic adpcmLowNibble, // ADPCM nibble in low bits
    output logic [7:0] silencePattern, // PCM write-back pattern
    output logic [15:0] crcStartValue, // HDLC CRC preset
    output logic [15:0] crcFinalMask, // HDLC CRC end mask
    output logic rxIrq // overflow interrupt, level
);
    typedef struct packed {
        logic [2:0] ctrl;
        logic [2:0] irqEn;
        logic [7:0] silence;
        logic [15:0] crcStart;
        logic [15:0] crcMask;
        logic [8:0] fifoBase;
        logic [2:0] fifoSize;
        logic [11:0] rdPtr;
        logic [15:0] rdData;
        logic rdValid;
    } regs_t;
    regs_t state;
    regs_t next_state;
    logic [2:0] ovfFlags;
    logic [2:0] ovfSet;
    logic [2:0] ovfClear;
    logic cellOvf;
    logic [11:0] wrPtr;
    logic txSlotFree;

    ////////////////////////////////////////////////////////////////////
    // sticky overflow flags, cleared by reading the status register
    assign ovfSet[HOST_PKT_OVF_BIT] = hostPktBufOvf;
    assign ovfSet[RX_CELL_OVF_BIT] = cellOvf;
    assign ovfSet[EVENT_OVF_BIT] = eventBufOvf;
    assign ovfClear = {3{cpuRd && cpuAddr == RX_OVERFLOW_STATUS_ADDR}};

    overflow_flag_bank #(
        .FLAGS(3)
    ) i_overflow_flag_bank (
        .ref_clk(ref_clk),
        .reset(reset),
        .setPulse(ovfSet),
        .clearMask(ovfClear),
        .flags(ovfFlags)
    );

    // receive cell fifo pointers and slot address
    rx_cell_fifo_ptr i_rx_cell_fifo_ptr (
        .ref_clk(ref_clk),
        .reset(reset),
        .sizeCode(state.fifoSize),
        .base(state.fifoBase),
        .rdPtr(state.rdPtr),
        .storeReq(rxCellReq),
        .storeAccept(rxCellAccept),
        .overflowPulse(cellOvf),
        .fifoFull(rxCellFifoFull),
        .fifoEmpty(rxCellFifoEmpty),
        .wrPtr(wrPtr),
        .storeAddr(rxCellAddr)
    );

    assign txSlotFree = 32'(txFifoLevel) < TX_FIFO_DEPTH;

    ////////////////////////////////////////////////////////////////////
    // register writes and read mux
    always_comb begin
        next_state = state;
        next_state.rdValid = cpuRd;
        if (cpuWr) begin
            unique case (cpuAddr)
                RX_CONTROL_ADDR: begin
                    next_state.ctrl = cpuWrData[2:0];
                end
                RX_OVERFLOW_IRQ_ENABLE_ADDR: begin
                    next_state.irqEn = cpuWrData[2:0];
                end
                PCM_SILENCE_PATTERN_ADDR: begin
                    next_state.silence = cpuWrData[7:0];
                end
                HDLC_CRC_START_VALUE_ADDR: begin
                    next_state.crcStart = cpuWrData;
                end
                HDLC_CRC_FINAL_MASK_ADDR: begin
                    next_state.crcMask = cpuWrData;
                end
                RX_CELL_FIFO_PLACEMENT_ADDR: begin
                    next_state.fifoBase = cpuWrData[FIFO_SIZE_LSB-1:FIFO_BASE_LSB];
                    next_state.fifoSize = cpuWrData[FIFO_SIZE_LSB+2:FIFO_SIZE_LSB];
                end
                RX_CELL_FIFO_READ_PTR_ADDR: begin
                    next_state.rdPtr = cpuWrData[11:0];
                end
                default: begin
                    // read-only and unmapped addresses ignore writes
                end
            endcase
        end
        next_state.rdData = 16'h0000;
        if (cpuRd) begin
            unique case (cpuAddr)
                TX_CELL_MONITOR_ADDR: next_state.rdData = {15'h0000, txSlotFree};
                RX_CONTROL_ADDR: next_state.rdData = {13'h0000, state.ctrl};
                RX_OVERFLOW_STATUS_ADDR: next_state.rdData = {13'h0000, ovfFlags};
                RX_OVERFLOW_IRQ_ENABLE_ADDR: next_state.rdData = {13'h0000, state.irqEn};
                PCM_SILENCE_PATTERN_ADDR: next_state.rdData = {8'h00, state.silence};
                HDLC_CRC_START_VALUE_ADDR: next_state.rdData = state.crcStart;
                HDLC_CRC_FINAL_MASK_ADDR: next_state.rdData = state.crcMask;
                RX_CELL_FIFO_PLACEMENT_ADDR: begin
                    next_state.rdData = {4'h0, state.fifoSize, state.fifoBase};
                end
                RX_CELL_FIFO_READ_PTR_ADDR: next_state.rdData = {4'h0, state.rdPtr};
                RX_CELL_FIFO_WRITE_PTR_ADDR: next_state.rdData = {4'h0, wrPtr};
                default: next_state.rdData = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.silence <= PCM_SILENCE_RESET[7:0];
            state.crcStart <= CRC_START_RESET;
            state.crcMask <= CRC_MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign cpuRdData = state.rdData;
    assign cpuRdValid = state.rdValid;
    assign hdlcByteMode = state.ctrl[HDLC_TYPE_BIT];
    assign rawCpsPacking = state.ctrl[PACKAGING_BIT];
    assign adpcmLowNibble = state.ctrl[NIBBLE_BIT];
    assign silencePattern = state.silence;
    assign crcStartValue = state.crcStart;
    assign crcFinalMask = state.crcMask;
    assign rxIrq = |(ovfFlags & state.irqEn);

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // after an enable write the interrupt follows the written enables against the flags
    a_irq_gating: assert property (cpuWr && cpuAddr == RX_OVERFLOW_IRQ_ENABLE_ADDR |=>
        rxIrq == |($past(cpuWrData[2:0]) & ovfFlags))
        else $error("interrupt does not follow flags and enables");
    a_ctrl_framing: assert property (cpuWr && cpuAddr == RX_CONTROL_ADDR |=>
        hdlcByteMode == $past(cpuWrData[0]) && rawCpsPacking == $past(cpuWrData[1]))
        else $error("control write did not set framing bits");
    a_ctrl_nibble: assert property (cpuWr && cpuAddr == RX_CONTROL_ADDR |=>
        adpcmLowNibble == $past(cpuWrData[2]))
        else $error("control write did not set nibble bit");
    a_host_ovf: assert property (hostPktBufOvf |=> ovfFlags[0])
        else $error("host buffer overflow not latched");
    a_cell_ovf: assert property (rxCellReq && rxCellFifoFull |=> ovfFlags[1] && !$changed(wrPtr))
        else $error("cell overflow not latched or pointer moved");
    a_event_ovf: assert property (eventBufOvf ##1 !eventBufOvf[*2] |-> ovfFlags[2]
        || $past(ovfClear[2]))
        else $error("event overflow flag lost without a read");
    a_wr_advance: assert property (rxCellAccept |=> wrPtr != $past(wrPtr))
        else $error("write pointer did not advance on store");
    a_full_refuse: assert property (rxCellFifoFull |-> !rxCellAccept && !rxCellFifoEmpty)
        else $error("cell accepted into a full fifo");
    a_rsvd_zero: assert property (cpuRd && cpuAddr == RX_OVERFLOW_STATUS_ADDR |=>
        cpuRdValid && cpuRdData[15:3] == 13'h0000)
        else $error("reserved status bits not zero");
    a_monitor_read: assert property (cpuRd && cpuAddr == TX_CELL_MONITOR_ADDR |=>
        cpuRdData[0] == (32'($past(txFifoLevel)) < TX_FIFO_DEPTH))
        else $error("monitor bit wrong");
    a_silence_write: assert property (cpuWr && cpuAddr == PCM_SILENCE_PATTERN_ADDR |=>
        silencePattern == $past(cpuWrData[7:0]))
        else $error("silence pattern not written");

    // crc registers take the whole written word
    a_crc_start: assert property (cpuWr && cpuAddr == HDLC_CRC_START_VALUE_ADDR |=>
        crcStartValue == $past(cpuWrData))
        else $error("crc start value not written");
    a_crc_mask: assert property (cpuWr && cpuAddr == HDLC_CRC_FINAL_MASK_ADDR |=>
        crcFinalMask == $past(cpuWrData))
        else $error("crc end mask not written");

    // a status read with no event in the same cycle leaves every flag clear
    a_status_clear: assert property (cpuRd && cpuAddr == RX_OVERFLOW_STATUS_ADDR
        && !hostPktBufOvf && !eventBufOvf && !(rxCellReq && rxCellFifoFull) |=>
        ovfFlags == 3'h0)
        else $error("status flags not cleared by read");

    // the hardware pointer ignores host writes
    a_wrptr_ro: assert property (cpuWr && cpuAddr == RX_CELL_FIFO_WRITE_PTR_ADDR
        && !rxCellAccept |=> $stable(wrPtr))
        else $error("write pointer moved on a host write");

    // in the smallest fifo every slot lies inside the base window on a 64 byte step
    a_cell_slot: assert property (rxCellAccept && state.fifoSize == 3'h0 |->
        rxCellAddr[20:12] == state.fifoBase && rxCellAddr[5:0] == 6'h00)
        else $error("cell slot address outside the fifo window");

    c_fifo_full: cover property (rxCellReq && rxCellFifoFull);
    c_irq_raise: cover property (!rxIrq ##1 rxIrq);
    c_status_read: cover property (cpuRd && cpuAddr == RX_OVERFLOW_STATUS_ADDR && |ovfFlags);
    c_fifo_drain: cover property (rxCellFifoFull ##1 rxCellFifoEmpty);
endmodule
`default_nettype wire

//--- verif/tb_rx_sar_control_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rx_sar_control_status_regs
    import rx_sar_regs_pkg::*;
;
    localparam int TB_DEPTH = 4;
    localparam logic [20:0] CELL_BASE = 21'h1a3000;
    logic ref_clk, reset, cpuWr, cpuRd, hostPktBufOvf, eventBufOvf, rxCellReq;
    logic [11:0] cpuAddr;
    logic [15:0] cpuWrData, cpuRdData, crcStartValue, crcFinalMask;
    logic [2:0] txFifoLevel;
    logic cpuRdValid, rxCellAccept, rxCellFifoFull, rxCellFifoEmpty, rxIrq;
    logic hdlcByteMode, rawCpsPacking, adpcmLowNibble;
    logic [20:0] rxCellAddr;
    logic [7:0] silencePattern;
    int miscompares = 0;
    int nTests = 0;
    // address map walk: address, value after reset, value after writing all ones
    logic [11:0] mapAddr [0:10] = '{12'h310, 12'h400, 12'h402, 12'h404, 12'h410, 12'h428,
        12'h42a, 12'h430, 12'h432, 12'h434, 12'h406};
    logic [15:0] rstVal [0:10] = '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h00ff,
        16'hffff, 16'hf0b8, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] onesVal [0:10] = '{16'h0001, 16'h0007, 16'h0000, 16'h0007, 16'h00ff,
        16'hffff, 16'hffff, 16'h0fff, 16'h0fff, 16'h0000, 16'h0000};

    ////////////////////////////////////////////////////////////////////////////////
    rx_sar_control_status_regs #(.TX_FIFO_DEPTH(TB_DEPTH)) i_rx_sar_control_status_regs (
        .ref_clk(ref_clk), .reset(reset), .cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuRd(cpuRd),
        .cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid),
        .txFifoLevel(txFifoLevel), .hostPktBufOvf(hostPktBufOvf), .eventBufOvf(eventBufOvf),
        .rxCellReq(rxCellReq), .rxCellAccept(rxCellAccept), .rxCellAddr(rxCellAddr),
        .rxCellFifoFull(rxCellFifoFull), .rxCellFifoEmpty(rxCellFifoEmpty),
        .hdlcByteMode(hdlcByteMode), .rawCpsPacking(rawCpsPacking),
        .adpcmLowNibble(adpcmLowNibble), .silencePattern(silencePattern),
        .crcStartValue(crcStartValue), .crcFinalMask(crcFinalMask), .rxIrq(rxIrq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic final_report();
        if (miscompares == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // compare on four-state values so unknowns never match
    task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
        nTests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one-cycle write strobe on the register port
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        cpuWr <= 1'b1;
        cpuAddr <= a;
        cpuWrData <= d;
        @(posedge ref_clk);
        cpuWr <= 1'b0;
    endtask

    // one-cycle read strobe, data checked in the cycle after it is taken
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        cpuRd <= 1'b1;
        cpuAddr <= a;
        @(posedge ref_clk);
        cpuRd <= 1'b0;
        #1;
        chk(cpuRdValid, 1'b1, "read valid");
        chk(cpuRdData, exp, "read data");
    endtask

    // offer one cell; request is left high so cells go back to back
    task automatic store(input logic expAcc, input int idx);
        @(posedge ref_clk);
        rxCellReq <= 1'b1;
        #1;
        chk(rxCellAccept, expAcc, "cell accept");
        if (expAcc) begin
            chk(rxCellAddr, CELL_BASE + 21'(idx * 64), "cell address");
        end
    endtask

    // host and event overflow inputs each driven to the given level for one cycle
    task automatic events(input logic host, input logic evt);
        @(posedge ref_clk);
        hostPktBufOvf <= host;
        eventBufOvf <= evt;
        @(posedge ref_clk);
        hostPktBufOvf <= 1'b0;
        eventBufOvf <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // free-running core clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end

    // main sequence
    initial begin
        reset = 1'b1;
        cpuWr = 1'b0;
        cpuRd = 1'b0;
        cpuAddr = 12'h000;
        cpuWrData = 16'h0000;
        txFifoLevel = 3'h0;
        hostPktBufOvf = 1'b0;
        eventBufOvf = 1'b0;
        rxCellReq = 1'b0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 11; i++) rd(mapAddr[i], rstVal[i]);
        for (int i = 0; i < 11; i++) wr(mapAddr[i], 16'hffff);
        for (int i = 0; i < 11; i++) rd(mapAddr[i], onesVal[i]);
        chk({adpcmLowNibble, rawCpsPacking, hdlcByteMode}, 3'h7, "control outputs");
        // each control bit alone drives only its own output
        for (int i = 0; i < 3; i++) begin
            wr(RX_CONTROL_ADDR, 16'h0001 << i);
            #1;
            chk({adpcmLowNibble, rawCpsPacking, hdlcByteMode}, 3'h1 << i, "ctl bit");
        end
        wr(HDLC_CRC_START_VALUE_ADDR, 16'h1234);
        wr(HDLC_CRC_FINAL_MASK_ADDR, 16'h5a5a);
        wr(PCM_SILENCE_PATTERN_ADDR, 16'h3c96);
        #1;
        chk(crcStartValue, 16'h1234, "crc start");
        chk(crcFinalMask, 16'h5a5a, "crc mask");
        chk(silencePattern, 8'h96, "silence");
        rd(PCM_SILENCE_PATTERN_ADDR, 16'h0096);
        // 4 KB fifo at base 1a3: 64 slots of 64 bytes
        wr(RX_OVERFLOW_IRQ_ENABLE_ADDR, 16'h0000);
        wr(RX_CELL_FIFO_READ_PTR_ADDR, 16'h0000);
        wr(RX_CELL_FIFO_PLACEMENT_ADDR, 16'hf1a3);
        rd(RX_CELL_FIFO_PLACEMENT_ADDR, 16'h01a3);
        chk({rxCellFifoFull, rxCellFifoEmpty}, 2'b01, "fifo empty");
        for (int i = 0; i < 64; i++) store(1'b1, i);
        store(1'b0, 0);
        @(posedge ref_clk);
        rxCellReq <= 1'b0;
        #1;
        chk({rxCellFifoFull, rxCellFifoEmpty}, 2'b10, "fifo full");
        rd(RX_CELL_FIFO_WRITE_PTR_ADDR, 16'h0040);
        wr(RX_CELL_FIFO_WRITE_PTR_ADDR, 16'h0000);
        rd(RX_CELL_FIFO_WRITE_PTR_ADDR, 16'h0040);
        events(1'b1, 1'b1);
        #1;
        chk(rxIrq, 1'b0, "irq masked");
        // every enable bit alone raises the interrupt with all flags set
        for (int i = 0; i < 3; i++) begin
            wr(RX_OVERFLOW_IRQ_ENABLE_ADDR, 16'h0001 << i);
            #1;
            chk(rxIrq, 1'b1, "irq enabled");
        end
        rd(RX_OVERFLOW_STATUS_ADDR, 16'h0007);
        rd(RX_OVERFLOW_STATUS_ADDR, 16'h0000);
        chk(rxIrq, 1'b0, "irq after clear");
        events(1'b1, 1'b0);
        wr(RX_OVERFLOW_IRQ_ENABLE_ADDR, 16'h0006);
        #1;
        chk(rxIrq, 1'b0, "irq other bits");
        wr(RX_OVERFLOW_IRQ_ENABLE_ADDR, 16'h0001);
        #1;
        chk(rxIrq, 1'b1, "irq own bit");
        rd(RX_OVERFLOW_STATUS_ADDR, 16'h0001);
        // host catches up: pointers equal again, then the slot index wraps
        wr(RX_CELL_FIFO_READ_PTR_ADDR, 16'h0040);
        #1;
        chk({rxCellFifoFull, rxCellFifoEmpty}, 2'b01, "fifo drained");
        store(1'b1, 0);
        @(posedge ref_clk);
        rxCellReq <= 1'b0;
        // 8 KB fifo: wrap bit moves up to bit 7, slot index to bits 6:0
        wr(RX_CELL_FIFO_PLACEMENT_ADDR, 16'h03a3);
        wr(RX_CELL_FIFO_READ_PTR_ADDR, 16'h00c1);
        #1;
        chk({rxCellFifoFull, rxCellFifoEmpty}, 2'b10, "8 KB full");
        chk(rxCellAddr, CELL_BASE + 21'(65 * 64), "8 KB slot address");
        // transmit monitor follows the fifo level against its depth
        @(posedge ref_clk);
        txFifoLevel <= 3'(TB_DEPTH - 1);
        rd(TX_CELL_MONITOR_ADDR, 16'h0001);
        @(posedge ref_clk);
        txFifoLevel <= 3'(TB_DEPTH);
        rd(TX_CELL_MONITOR_ADDR, 16'h0000);
        // a second reset in mid-run restores the defaults
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd(HDLC_CRC_START_VALUE_ADDR, 16'hffff);
        rd(RX_CELL_FIFO_WRITE_PTR_ADDR, 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
